// file: src/banked_regfile.sv
// What this block does
// - Bank 0 splits into ports 0-3, storage 4-239, control 240-255.
// - Indirect access uses a full eight-bit register address; direct does too except for Ex, which names a working register.
// - Short four-bit operands see sixteen groups of sixteen registers.
// - Group select pointer gives the start of the active working group.
// - Group E0-EF is reached only by working or indirect addressing.
// - Locations 0-15 come in sixteen selectable banks; only banks 0 and D hold registers.
// - Timer controls sit in bank D; pointer 0Dh shows them as group 0.
// - Pointer 7Dh maps bank D low and working group 7 elsewhere.
// - Timer pair control bits 4..0 always read as ones.
//
// Register file address decode for an 8-bit core, with expanded banks.
// Assumes the core issues at most one access per cycle on mclk and reads
// the answer one cycle later; port pins are asynchronous to mclk.
`timescale 1ns/1ps
`include "regfile_defs.svh"
module banked_regfile
  import regfile_pkg::*;
#(
  parameter int PORTS = 4
)
(
  input  wire logic               mclk,
  input  wire logic               arst_n,
  input  wire op_req_t            req,
  output op_rsp_t                 rsp,
  input  wire logic [PORTS*8-1:0] port_pins,
  output logic      [PORTS*8-1:0] port_drive,
  output logic      [7:0]         group_select_pointer,
  output logic      [127:0]       timer_bank
);

  logic [7:0]         full_addr;
  logic               low_group;
  logic               expanded;
  logic               bank_d_hit;
  logic               ptr_hit;
  logic               port_hit;
  logic               mem_we;
  area_t              area;
  logic [PORTS*8-1:0] pin_meta;
  logic [PORTS*8-1:0] pin_sync;
  logic [7:0]         mem_rdata;
  logic [7:0]         bank_d [0:15];
  logic [7:0]         next_bank_d [0:15];
  logic [7:0]         next_pointer;
  logic [PORTS*8-1:0] next_port_drive;
  logic               rsp_valid;
  logic               next_rsp_valid;
  area_t              rsp_area;
  area_t              next_rsp_area;
  logic               rsp_from_mem;
  logic               next_rsp_from_mem;
  logic [7:0]         rsp_held;
  logic [7:0]         next_rsp_held;

  // Operand address resolution
  always_comb
  begin
    case (req.mode)
      MODE_WORKING:
        full_addr = {group_select_pointer[7:4], req.addr[3:0]};
      MODE_DIRECT:
        // Ex in an 8-bit field names a working register, not group E
        if (req.addr[7:4] == `RF_ESCAPE_GROUP)
          full_addr = {group_select_pointer[7:4], req.addr[3:0]};
        else
          full_addr = req.addr;
      MODE_INDIRECT:
        full_addr = req.addr;
      default:
        full_addr = req.addr;
    endcase
  end

  // Bank selection only touches locations 00-0F of the address space
  assign low_group  = (full_addr[7:4] == `RF_LOW_GROUP);
  assign expanded   = low_group
                      && (group_select_pointer[3:0] != `RF_BANK_MAIN);
  assign bank_d_hit = low_group
                      && (group_select_pointer[3:0] == `RF_BANK_TIMER);
  assign ptr_hit    = (full_addr == `RF_PTR_ADDR);
  assign port_hit   = !expanded && (full_addr <= `RF_PORT_LAST);
  assign mem_we     = req.valid && req.write && !expanded && !ptr_hit
                      && !port_hit;

  // Region decode of the resolved bank-0 address
  always_comb
  begin
    if (expanded)
      area = AREA_EXPANDED;
    else if (full_addr <= `RF_PORT_LAST)
      area = AREA_PORT;
    else if (full_addr <= `RF_GP_LAST)
      area = AREA_GENERAL;
    else
      area = AREA_CONTROL;
  end

  // Two flops on every port pin bit before any logic reads it
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= port_pins;
      pin_sync <= pin_meta;
    end
  end

  ram_byte_store #(
    .AW (8),
    .DW (8)
  ) u_store (
    .mclk   (mclk),
    .arst_n (arst_n),
    .we     (mem_we),
    .addr   (full_addr),
    .wdata  (req.wdata),
    .rdata  (mem_rdata)
  );

  // Pointer, port output and bank D next values
  always_comb
  begin
    next_pointer    = group_select_pointer;
    next_port_drive = port_drive;
    for (int i = 0; i < 16; i++)
      next_bank_d[i] = bank_d[i];
    if (req.valid && req.write)
    begin
      if (bank_d_hit)
        next_bank_d[full_addr[3:0]] = req.wdata;
      else if (ptr_hit)
        next_pointer = req.wdata;
      else if (port_hit)
        next_port_drive[full_addr[1:0]*8 +: 8] = req.wdata;
    end
  end

  // Bank D registers; banks other than 0 and D are empty
  generate
    for (genvar g = 0; g < 16; g++)
    begin : g_bank_d
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
          bank_d[g] <= `RF_BANKD_RESET;
        else
          bank_d[g] <= next_bank_d[g];
      end
      assign timer_bank[g*8 +: 8] = bank_d[g];
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      group_select_pointer <= `RF_PTR_RESET;
      port_drive           <= '0;
    end
    else
    begin
      group_select_pointer <= next_pointer;
      port_drive           <= next_port_drive;
    end
  end

  // Answer pipeline: one cycle after the request, reads and writes alike
  always_comb
  begin
    next_rsp_valid    = req.valid;
    next_rsp_area     = area;
    next_rsp_from_mem = 1'b0;
    next_rsp_held     = 8'h00;
    if (bank_d_hit)
    begin
      next_rsp_held = bank_d[full_addr[3:0]];
      if (full_addr[3:0] == `RF_TPC_OFFSET)
        next_rsp_held = next_rsp_held | `RF_TPC_RSVD_MASK;
    end
    else if (expanded)
      next_rsp_held = 8'h00;
    else if (ptr_hit)
      next_rsp_held = group_select_pointer;
    else if (port_hit)
      next_rsp_held = pin_sync[full_addr[1:0]*8 +: 8];
    else
      next_rsp_from_mem = 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_valid    <= 1'b0;
      rsp_area     <= AREA_PORT;
      rsp_from_mem <= 1'b0;
      rsp_held     <= 8'h00;
    end
    else
    begin
      rsp_valid    <= next_rsp_valid;
      rsp_area     <= next_rsp_area;
      rsp_from_mem <= next_rsp_from_mem;
      rsp_held     <= next_rsp_held;
    end
  end

  // Both sources are flops; the mux only picks between them
  assign rsp.valid = rsp_valid;
  assign rsp.area  = rsp_area;
  assign rsp.data  = rsp_from_mem ? mem_rdata : rsp_held;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_ptr_load;
    req.valid && req.write && ptr_hit;
  endsequence

  sequence s_tpc_read;
    req.valid && !req.write && bank_d_hit
      && full_addr[3:0] == `RF_TPC_OFFSET;
  endsequence

  a_port_area: assert property (
    req.valid && !expanded && full_addr <= 8'h03 |=> rsp.area == AREA_PORT)
    else $error("port range not decoded as port");

  a_ctrl_area: assert property (
    req.valid && full_addr >= 8'hf0 |=> rsp.area == AREA_CONTROL)
    else $error("control range not decoded as control");

  a_direct_full: assert property (
    req.mode == MODE_DIRECT && req.addr[7:4] != 4'he
      |-> full_addr == req.addr)
    else $error("direct address altered");

  a_group_start: assert property (
    req.mode == MODE_WORKING
      |-> full_addr[7:4] == group_select_pointer[7:4])
    else $error("working access left its group");

  a_working_join: assert property (
    req.mode == MODE_WORKING |-> full_addr[3:0] == req.addr[3:0])
    else $error("working operand offset wrong");

  a_escape_group: assert property (
    req.mode == MODE_DIRECT && req.addr[7:4] == 4'he
      && group_select_pointer[7:4] != 4'he |-> full_addr[7:4] != 4'he)
    else $error("group E reached by direct address");

  a_ptr_load: assert property (
    s_ptr_load |=> group_select_pointer == $past(req.wdata))
    else $error("pointer not loaded");

  a_bank_d_map: assert property (
    req.valid && req.write && bank_d_hit
      && full_addr[3:0] != 4'h3
      |=> timer_bank[$past(full_addr[3:0])*8 +: 8] == $past(req.wdata))
    else $error("bank D write lost");

  a_split_map: assert property (
    group_select_pointer == 8'h7d && req.valid
      && req.mode == MODE_WORKING |=> rsp.area != AREA_EXPANDED)
    else $error("working group 7 hit expanded bank");

  a_rsvd_ones: assert property (
    s_tpc_read ##1 rsp.valid |-> rsp.data[4:0] == 5'h1f)
    else $error("reserved timer bits not ones");

endmodule : banked_regfile

// file: src/regfile_defs.svh
// Address map constants for the banked register file.
// Assumes 8-bit register addresses and a 4-bit bank field in the pointer.
`ifndef REGFILE_DEFS_SVH
`define REGFILE_DEFS_SVH

`define RF_PORT_LAST     8'h03
`define RF_GP_LAST       8'hef
`define RF_ESCAPE_GROUP  4'he
`define RF_LOW_GROUP     4'h0
`define RF_PTR_ADDR      8'hfd
`define RF_PTR_RESET     8'h00
`define RF_BANK_MAIN     4'h0
`define RF_BANK_TIMER    4'hd
`define RF_TPC_OFFSET    4'h3
`define RF_TPC_RSVD_MASK 8'h1f
`define RF_TPC_RESET     8'h00
`define RF_BANKD_RESET   8'h00
`define RF_PORT_RESET    8'h00

`endif

// file: src/regfile_pkg.sv
// Types shared by the register file, the operand core and the bench.
// Assumes the core presents one operand access per cycle at most.
package regfile_pkg;

  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_WORKING,
    MODE_INDIRECT
  } addr_mode_t;

  typedef enum logic [1:0] {
    AREA_PORT,
    AREA_GENERAL,
    AREA_CONTROL,
    AREA_EXPANDED
  } area_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    addr_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } op_req_t;

  typedef struct packed {
    logic       valid;
    area_t      area;
    logic [7:0] data;
  } op_rsp_t;

endpackage : regfile_pkg

// file: src/ram_byte_store.sv
// Byte-wide storage array with one shared address and registered read.
// Assumes the caller gates the write enable; contents are not reset.
`timescale 1ns/1ps
module ram_byte_store
#(
  parameter int AW = 8,
  parameter int DW = 8
)
(
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] store [0:(1<<AW)-1];

  // Array write; no reset so it maps onto plain RAM
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      store[addr] <= wdata;
    end
  end

  // Read data leaves from a register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= store[addr];
    end
  end

endmodule : ram_byte_store

// file: verif/operand_core.sv
// Core-side operand requester: one access at a time, then the answer.
// Assumes the register file answers within a few mclk cycles.
`timescale 1ns/1ps
module operand_core
  import regfile_pkg::*;
(
  input  wire logic    mclk,
  output op_req_t      req,
  input  wire op_rsp_t rsp
);
  // Quiet bus at time zero
  initial req = '0;

  // Valid drops and write, address and data are inverted once released (mode is kept), so stale values never look valid
  task automatic access(input logic w, input addr_mode_t m,
                        input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output area_t ar);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{1'h1, w, m, a, d};
    @(posedge mclk);
    req <= '{1'h0, ~w, m, ~a, ~d};
    #1;
    while (rsp.valid !== 1'h1 && n < 4)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    q = rsp.data;
    ar = rsp.area;
  endtask : access
endmodule : operand_core

// file: verif/tb.sv
// Self-checking bench for the banked register file address decode.
// Assumes operand_core drives the request port; pins change once, for the sync test.
`timescale 1ns/1ps
module tb;
  import regfile_pkg::*;
  typedef struct packed {
    logic       w;
    addr_mode_t m;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    area_t      ar;
  } row_t;
  localparam addr_mode_t DI = MODE_DIRECT;
  localparam addr_mode_t WK = MODE_WORKING;
  localparam addr_mode_t IN = MODE_INDIRECT;
  localparam area_t PO = AREA_PORT;
  localparam area_t GE = AREA_GENERAL;
  localparam area_t CO = AREA_CONTROL;
  localparam area_t EX = AREA_EXPANDED;
  localparam int NR = 34;
  logic         mclk;
  logic         arst_n;
  op_req_t      req;
  op_rsp_t      rsp;
  logic [31:0]  port_pins;
  logic [31:0]  port_drive;
  logic [7:0]   group_select_pointer;
  logic [127:0] timer_bank;
  logic [7:0]   q;
  area_t        ar;
  int           fail_count = 0;
  int           n_tests = 0;
  int           cyc = 0;
  // Ordinary cases: write/read pairs, pointer moves between them
  row_t rows [0:NR-1] = '{
    '{1'h1,DI,8'h04,8'ha5,8'h00,GE}, '{1'h0,DI,8'h04,8'h00,8'ha5,GE},
    '{1'h1,IN,8'hef,8'h3c,8'h00,GE}, '{1'h0,IN,8'hef,8'h00,8'h3c,GE},
    '{1'h1,DI,8'h03,8'h81,8'h00,PO}, '{1'h0,DI,8'h00,8'h00,8'h0f,PO},
    '{1'h0,DI,8'h01,8'h00,8'h96,PO}, '{1'h1,DI,8'hf0,8'h11,8'h00,CO},
    '{1'h0,DI,8'hf0,8'h00,8'h11,CO}, '{1'h1,DI,8'hfd,8'h20,8'h00,CO},
    '{1'h0,DI,8'hfd,8'h00,8'h20,CO}, '{1'h1,WK,8'h05,8'h77,8'h00,GE},
    '{1'h0,IN,8'h25,8'h00,8'h77,GE}, '{1'h1,IN,8'he3,8'h99,8'h00,GE},
    '{1'h1,DI,8'he3,8'h44,8'h00,GE}, '{1'h0,IN,8'he3,8'h00,8'h99,GE},
    '{1'h0,IN,8'h23,8'h00,8'h44,GE}, '{1'h1,DI,8'hfd,8'h0d,8'h00,CO},
    '{1'h1,WK,8'h00,8'h12,8'h00,EX}, '{1'h1,WK,8'h03,8'ha0,8'h00,EX},
    '{1'h0,WK,8'h03,8'h00,8'hbf,EX}, '{1'h1,DI,8'hfd,8'h7d,8'h00,CO},
    '{1'h0,DI,8'h03,8'h00,8'hbf,EX}, '{1'h1,DI,8'h01,8'hc3,8'h00,EX},
    '{1'h1,WK,8'h01,8'h66,8'h00,GE}, '{1'h0,IN,8'h71,8'h00,8'h66,GE},
    '{1'h1,DI,8'hfd,8'h05,8'h00,CO}, '{1'h1,DI,8'h02,8'hff,8'h00,EX},
    '{1'h0,DI,8'h02,8'h00,8'h00,EX}, '{1'h1,DI,8'hfd,8'he0,8'h00,CO},
    '{1'h1,WK,8'h02,8'h5a,8'h00,GE}, '{1'h0,IN,8'he2,8'h00,8'h5a,GE},
    '{1'h1,DI,8'hfd,8'h00,8'h00,CO}, '{1'h1,DI,8'h02,8'hc7,8'h00,PO}};

  banked_regfile banked_regfile_inst (
    .mclk                 (mclk),
    .arst_n               (arst_n),
    .req                  (req),
    .rsp                  (rsp),
    .port_pins            (port_pins),
    .port_drive           (port_drive),
    .group_select_pointer (group_select_pointer),
    .timer_bank           (timer_bank)
  );
  operand_core operand_core_inst (
    .mclk (mclk),
    .req  (req),
    .rsp  (rsp)
  );

  // 200 MHz core clock
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Hang guard, far above the roughly 90 cycles the run needs
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  // Main sequence
  initial
  begin
    arst_n = 1'h0;
    port_pins = 32'h5ac3960f;
    repeat (10) @(posedge mclk);
    arst_n <= 1'h1;
    for (int i = 0; i < NR; i++)
    begin
      operand_core_inst.access(rows[i].w, rows[i].m, rows[i].a,
                               rows[i].d, q, ar);
      if (!rows[i].w) check(q, rows[i].q);
      check(ar, rows[i].ar);
      check(rsp.valid, 32'h1);
      $display("Row %0d done", i);
    end
    // Side outputs after the table: port latches and bank D contents
    check(port_drive, 32'h81c70000);
    check(timer_bank[31:0], 32'ha000c312);
    check(timer_bank[63:32], 32'h0);
    check(group_select_pointer, 32'h0);
    $display("Output checks done");
    // Pin change shows on a read issued after both synchroniser flops have taken it
    @(posedge mclk);
    port_pins <= 32'h5ac396f0;
    repeat (2) @(posedge mclk);
    operand_core_inst.access(1'h0, DI, 8'h00, 8'h00, q, ar);
    check(q, 32'hf0);
    check(ar, PO);
    $display("Pin sync test done");
    // Second reset in mid-run clears the pointer and bank D
    operand_core_inst.access(1'h1, DI, 8'hfd, 8'h3c, q, ar);
    check(group_select_pointer, 32'h3c);
    @(posedge mclk);
    arst_n <= 1'h0;
    @(posedge mclk);
    #1;
    check(group_select_pointer, 32'h0);
    check(timer_bank[31:0], 32'h0);
    check(rsp.valid, 32'h0);
    @(posedge mclk);
    arst_n <= 1'h1;
    operand_core_inst.access(1'h0, DI, 8'hfd, 8'h00, q, ar);
    check(q, 32'h0);
    $display("Reset test done");
    wrap_up();
  end
endmodule : tb
